// file: design/adc_acq_pkg.sv
package adc_acq_pkg;

    // sample geometry
    localparam int NUM_CHANNELS   = 3;
    localparam int SAMPLE_WIDTH   = 24;
    localparam int GAIN_CODE_W    = 3;   // code n selects gain 2**n, 1..128
    localparam int PHASE_W        = 10;

    // clocking: modulator runs at half the master clock
    localparam int MOD_CLK_DIV    = 2;
    localparam int OSR            = 512;
    // output samples every OSR modulator ticks = 1024 master clocks (8 kS/s at 8.192 MHz)
    localparam int FRAME_CLKS     = OSR * MOD_CLK_DIV;
    localparam int FRAME_CNT_W    = 10;
    localparam logic [FRAME_CNT_W-1:0] FRAME_LAST = 10'(FRAME_CLKS - 1);

    // reset values of configuration
    localparam logic [GAIN_CODE_W-1:0] GAIN_RESET = 3'h0;

    // crc16 polynomial x^16+x^12+x^5+1, seed all ones
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_SEED = 16'hffff;

    typedef logic signed [SAMPLE_WIDTH-1:0] sample_t;

    // one set of three results, simultaneous when the channel phases are equal, plus its check word
    typedef struct packed {
        sample_t [NUM_CHANNELS-1:0] ch;
        logic [15:0]                crc;
        logic                       crc_valid;
    } frame_t;

    // per-channel calibration carried together
    typedef struct packed {
        logic signed [SAMPLE_WIDTH-1:0] offset;
        logic [SAMPLE_WIDTH-1:0]        gain;     // unsigned, 1.23 fixed point
        logic signed [PHASE_W-1:0]      phase;    // delay in modulator ticks
        logic [GAIN_CODE_W-1:0]         pga_code;
    } chan_cfg_t;

endpackage : adc_acq_pkg

// file: design/adc_sample_acquisition.sv
`timescale 1ns/1ns
`default_nettype none

module adc_sample_acquisition
(
    input  wire logic                                   ref_clk_i,   // master clock from host
    input  wire logic                                   srst_i,
    input  wire adc_acq_pkg::sample_t [adc_acq_pkg::NUM_CHANNELS-1:0] raw_sample_i,
    input  wire adc_acq_pkg::chan_cfg_t [adc_acq_pkg::NUM_CHANNELS-1:0] chan_cfg_i,
    input  wire logic                                   out_crc_en_i,
    input  wire logic                                   in_crc_en_i,
    input  wire logic                                   in_frame_valid_i,
    input  wire logic [15:0]                            in_frame_word_i,
    input  wire logic [15:0]                            in_frame_crc_i,
    input  wire logic                                   reg_crc_en_i,
    input  wire logic [15:0]                            reg_map_word_i,
    input  wire logic                                   host_ready_i,
    output logic                                        mod_clk_o,
    output logic                                        sample_ready_flag_o,
    output adc_acq_pkg::frame_t                         frame_o,
    output logic                                        in_crc_err_o,
    output logic [15:0]                                 reg_crc_o,
    output logic                                        overrun_o,
    output logic [adc_acq_pkg::NUM_CHANNELS-1:0][adc_acq_pkg::GAIN_CODE_W-1:0] pga_code_o
);

    logic [adc_acq_pkg::FRAME_CNT_W-1:0] frame_cnt;
    logic                                frame_tick;
    adc_acq_pkg::frame_t                 new_frame;
    adc_acq_pkg::sample_t [adc_acq_pkg::NUM_CHANNELS-1:0] cal_sample;
    adc_acq_pkg::frame_t                 buf_mem [2];
    logic                                wr_ptr;
    logic                                rd_ptr;
    logic [1:0]                          fill;
    logic                                buf_ready;
    logic                                buf_valid;

    // bitwise crc16 over one 16-bit word
    function automatic logic [15:0] crc16_word(input logic [15:0] crc, input logic [15:0] data);
        logic [15:0] c;
        c = crc;
        for (int i = 15; i >= 0; i--)
        begin
            if (c[15] ^ data[i])
                c = (c << 1) ^ adc_acq_pkg::CRC_POLY;
            else
                c = c << 1;
        end
        return c;
    endfunction : crc16_word

    // modulator clock toggles on every rising master edge, giving half the master rate
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            mod_clk_o <= 1'b0;
        else
            mod_clk_o <= ~mod_clk_o;
    end

    // decimation counter: one output set per OSR modulator ticks
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            frame_cnt <= '0;
        else if (frame_cnt == adc_acq_pkg::FRAME_LAST)
            frame_cnt <= '0;
        else
            frame_cnt <= frame_cnt + 1'b1;
    end
    assign frame_tick = (frame_cnt == adc_acq_pkg::FRAME_LAST);

    // gain selection codes forwarded to the analog stage, held in reset at unity
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            pga_code_o <= '{default: adc_acq_pkg::GAIN_RESET};
        else
            for (int k = 0; k < adc_acq_pkg::NUM_CHANNELS; k++)
                pga_code_o[k] <= chan_cfg_i[k].pga_code;
    end

    // calibration per channel: phase moves the capture instant of a channel
    // by whole modulator ticks around mid-frame, so equal phases keep the
    // channels simultaneous; a phase beyond half a frame wraps into the
    // neighbouring frame, which the host has to avoid
    generate
        for (genvar g = 0; g < adc_acq_pkg::NUM_CHANNELS; g++)
        begin : g_cal
            int                                          capture_pos;
            logic [adc_acq_pkg::FRAME_CNT_W-1:0]         capture_at;
            adc_acq_pkg::sample_t                        held;
            logic signed [2*adc_acq_pkg::SAMPLE_WIDTH:0] prod;
            logic signed [adc_acq_pkg::SAMPLE_WIDTH:0]   shifted;

            // capture point in master clocks; low bits wrap modulo the frame
            always_comb
            begin
                capture_pos = adc_acq_pkg::FRAME_CLKS / 2
                              + adc_acq_pkg::MOD_CLK_DIV * int'(chan_cfg_i[g].phase);
            end
            assign capture_at = capture_pos[adc_acq_pkg::FRAME_CNT_W-1:0];

            // raw result held until the frame tick picks it up
            always_ff @(posedge ref_clk_i)
            begin
                if (frame_cnt == capture_at)
                    held <= raw_sample_i[g];
            end

            // offset removed first, then gain in 1.23 fixed point, truncated
            always_comb
            begin
                shifted = $signed({held[adc_acq_pkg::SAMPLE_WIDTH-1], held})
                          - $signed({chan_cfg_i[g].offset[adc_acq_pkg::SAMPLE_WIDTH-1],
                                     chan_cfg_i[g].offset});
                prod = 49'(shifted * $signed({1'b0, chan_cfg_i[g].gain}));
                cal_sample[g] = prod[23 +: adc_acq_pkg::SAMPLE_WIDTH];
            end
        end
    endgenerate

    // all channels enter the buffer on the same frame tick; results are simultaneous only when the channel phases are equal
    always_comb
    begin
        logic [15:0] c;
        c = adc_acq_pkg::CRC_SEED;
        new_frame.ch = cal_sample;
        for (int k = 0; k < adc_acq_pkg::NUM_CHANNELS; k++)
        begin
            c = crc16_word(c, cal_sample[k][23:8]);
            c = crc16_word(c, {cal_sample[k][7:0], 8'h00});
        end
        new_frame.crc       = out_crc_en_i ? c : 16'h0000;
        new_frame.crc_valid = out_crc_en_i;
    end

    // two-entry buffer: a slow host stalls without losing a set; a third
    // pending set is dropped and reported, older data is kept in order
    assign buf_ready = (fill != 2'd2);
    assign buf_valid = (fill != 2'd0);

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            wr_ptr <= 1'b0;
        else if (frame_tick && buf_ready)
        begin
            buf_mem[wr_ptr] <= new_frame;
            wr_ptr          <= ~wr_ptr;
        end
    end

    // head advances on every accepted pop
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            rd_ptr <= 1'b0;
        else if (buf_valid && host_ready_i)
            rd_ptr <= ~rd_ptr;
    end

    // occupancy: a push and a pop in one cycle cancel
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            fill <= 2'd0;
        else
            fill <= fill + 2'((frame_tick && buf_ready) ? 1 : 0)
                         - 2'((buf_valid && host_ready_i) ? 1 : 0);
    end

    // overrun is sticky until reset so the host learns a set was missed
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            overrun_o <= 1'b0;
        else if (frame_tick && !buf_ready)
            overrun_o <= 1'b1;
    end

    // ready flag follows buffer occupancy; data taken from flops at head
    // a pop needs the flag and host_ready_i on the same edge
    assign sample_ready_flag_o = buf_valid;
    assign frame_o = buf_mem[rd_ptr];

    // crc check of host-to-converter words when enabled
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            in_crc_err_o <= 1'b0;
        else if (in_frame_valid_i)
            in_crc_err_o <= in_crc_en_i &&
                (crc16_word(adc_acq_pkg::CRC_SEED, in_frame_word_i) != in_frame_crc_i);
    end

    // running crc over register map contents, one word per clock, restarted by disable
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i || !reg_crc_en_i)
            reg_crc_o <= adc_acq_pkg::CRC_SEED;
        else
            reg_crc_o <= crc16_word(reg_crc_o, reg_map_word_i);
    end

endmodule : adc_sample_acquisition

`default_nettype wire

// file: bench/acq_checker_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module acq_checker
(
    input wire logic                         ref_clk_i,
    input wire logic                         srst_i,
    input wire adc_acq_pkg::chan_cfg_t [2:0] chan_cfg_i,
    input wire logic                         reg_crc_en_i,
    input wire logic                         in_frame_valid_i,
    input wire logic                         host_ready_i,
    input wire logic                         mod_clk_o,
    input wire logic                         sample_ready_flag_o,
    input wire adc_acq_pkg::frame_t          frame_o,
    input wire logic                         in_crc_err_o,
    input wire logic [15:0]                  reg_crc_o,
    input wire logic                         overrun_o,
    input wire logic [2:0][2:0]              pga_code_o
);
    // one clock domain, so reset cancels any attempt in flight
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);
    mod_clk_half_a: assert property (!$past(srst_i) |-> mod_clk_o != $past(mod_clk_o))
        else $error("mod clk stuck");
    flag_holds_a: assert property (sample_ready_flag_o && !host_ready_i |=>
        sample_ready_flag_o && $stable(frame_o)) else $error("frame lost unread");
    // a drop caused by reset itself is not a pop
    flag_drop_a: assert property (!$past(srst_i) && $fell(sample_ready_flag_o) |->
        $past(host_ready_i)) else $error("flag fell unpopped");
    ovr_sticky_a: assert property (overrun_o |=> overrun_o) else $error("overrun cleared");
    ovr_cause_a: assert property ($rose(overrun_o) |-> $past(sample_ready_flag_o))
        else $error("overrun while empty");
    pga_copy_a: assert property (!$past(srst_i) |-> pga_code_o == {$past(chan_cfg_i[2].pga_code),
        $past(chan_cfg_i[1].pga_code), $past(chan_cfg_i[0].pga_code)}) else $error("gain code");
    reg_crc_idle_a: assert property (!reg_crc_en_i |=> reg_crc_o == 16'hffff)
        else $error("reg crc not idle");
    err_hold_a: assert property (!in_frame_valid_i |=> $stable(in_crc_err_o))
        else $error("crc error moved");
endmodule : acq_checker
bind adc_sample_acquisition acq_checker u_chk (.ref_clk_i, .srst_i, .chan_cfg_i, .reg_crc_en_i,
    .in_frame_valid_i, .host_ready_i, .mod_clk_o, .sample_ready_flag_o, .frame_o, .in_crc_err_o,
    .reg_crc_o, .overrun_o, .pga_code_o);
`default_nettype wire

// file: bench/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model
(
    input  wire logic ref_clk_i,
    input  wire logic stall_i,
    input  wire logic sample_ready_flag_i,
    output var logic  host_ready_o
);
    initial host_ready_o = 1'b0;
    // one pop then a gap: each set is read whole before the next; stall_i stops all pops
    // one pop stands for the whole serial burst of the used channels
    always @(posedge ref_clk_i)
        host_ready_o <= #1 sample_ready_flag_i && !stall_i && !host_ready_o;
endmodule : host_model
`default_nettype wire

// file: bench/adc_sample_acquisition_tb.sv
`timescale 1ns/1ns
`default_nettype none
module adc_sample_acquisition_tb;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ocrc = 1'b0, ival = 1'b0, rcrc = 1'b0, icrc = 1'b1, stall = 1'b1, hrdy, flag, err, ovr, mclk;
    logic [15:0] iw = 16'h0, icw = 16'h0, rc;
    logic [2:0][2:0] programmable_gain_stage;
    adc_acq_pkg::sample_t [2:0] raw = '0;
    adc_acq_pkg::chan_cfg_t [2:0] cfg = '0;
    adc_acq_pkg::frame_t fr;
    int fail_count = 0, checks_done = 0, cyc = 0;
    adc_sample_acquisition u_dut (.ref_clk_i, .srst_i, .raw_sample_i(raw), .chan_cfg_i(cfg),
        .out_crc_en_i(ocrc), .in_crc_en_i(icrc), .in_frame_valid_i(ival), .in_frame_word_i(iw),
        .in_frame_crc_i(icw), .reg_crc_en_i(rcrc), .reg_map_word_i(iw), .host_ready_i(hrdy),
        .mod_clk_o(mclk), .sample_ready_flag_o(flag), .frame_o(fr), .in_crc_err_o(err),
        .reg_crc_o(rc), .overrun_o(ovr), .pga_code_o(programmable_gain_stage));
    host_model u_host (.ref_clk_i, .stall_i(stall), .sample_ready_flag_i(flag), .host_ready_o(hrdy));
    always #20 ref_clk_i = ~ref_clk_i;
    // hang guard, well past the seven frame periods the run needs
    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            end_sim;
        end
    end
    task automatic tick;
        @(posedge ref_clk_i);
        #1;
    endtask : tick
    task automatic chk(input string n, input logic [71:0] e, input logic [71:0] g);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s exp %0h got %0h", n, e, g);
        end
    endtask : chk
    task automatic wait_flag(input logic v);
        for (int k = 0; k < 1100 && flag !== v; k++)
            tick;
        chk("flag", 72'(v), 72'(flag));
    endtask : wait_flag
    task automatic drain;
        stall = 1'b0;
        wait_flag(1'b0);
        stall = 1'b1;
    endtask : drain
    // bitwise msb-first crc, kept apart from the block's own engine
    function automatic logic [15:0] crc16(input logic [15:0] c, input logic [15:0] w);
        for (int i = 15; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction : crc16
    task automatic t_frame;
        int t0;
        raw = {24'h7fffff, 24'h800000, 24'h00a5c3};
        wait_flag(1'b1);
        t0 = cyc;
        chk("samples", 72'(raw), 72'(fr.ch));
        chk("used pair", 72'(raw[1:0]), 72'(fr.ch[1:0]));
        chk("crc off", 72'h0, 72'({fr.crc_valid, fr.crc}));
        drain;
        wait_flag(1'b1);
        chk("period", 72'(adc_acq_pkg::FRAME_CLKS), 72'(cyc - t0));
        drain;
        $display("frame test done");
    endtask : t_frame
    task automatic t_cal;
        for (int c = 0; c < 8; c++)
        begin
            for (int i = 0; i < 3; i++)
                cfg[i].pga_code = 3'(c);
            tick;
            tick;
            chk("pga", 72'({3{3'(c)}}), 72'(programmable_gain_stage));
        end
        for (int i = 0; i < 3; i++)
            cfg[i] = '{24'h000456, 24'h400000, 10'h3ff, 3'h5};
        raw = {3{24'h123456}};
        wait_flag(1'b1);
        chk("cal", 72'({3{24'h091800}}), 72'(fr.ch));
        drain;
        $display("cal test done");
    endtask : t_cal
    task automatic t_crc;
        logic [15:0] c;
        ocrc = 1'b1;
        iw = 16'hbeef;
        icw = crc16(16'hffff, iw);
        c = 16'hffff;
        // unity calibration, so the next frame carries the raw words
        for (int i = 0; i < 3; i++)
        begin
            cfg[i].offset = 24'h000000;
            cfg[i].gain   = 24'h800000;
        end
        // good word, bad word, bad word with checking off; reg crc folds each one
        ival = 1'b1;
        rcrc = 1'b1;
        for (int b = 0; b < 3; b++)
        begin
            icw[0] = icw[0] ^ (b == 1);
            icrc = (b != 2);
            c = crc16(c, iw);
            tick;
            chk("in crc", 72'(b == 1), 72'(err));
            chk("reg crc on", 72'(c), 72'(rc));
        end
        ival = 1'b0;
        rcrc = 1'b0;
        icrc = 1'b1;
        tick;
        chk("reg crc off", 72'hffff, 72'(rc));
        c = 16'hffff;
        for (int i = 0; i < 3; i++)
            c = crc16(crc16(c, raw[i][23:8]), {raw[i][7:0], 8'h00});
        wait_flag(1'b1);
        chk("crc on", 72'({1'b1, c}), 72'({fr.crc_valid, fr.crc}));
        drain;
        ocrc = 1'b0;
        $display("crc test done");
    endtask : t_crc
    task automatic t_over;
        repeat (3 * adc_acq_pkg::FRAME_CLKS + 40) tick;
        chk("overrun", 72'h1, 72'(ovr));
        drain;
        chk("sticky", 72'h1, 72'(ovr));
        // mid-run reset clears the sticky flag and restarts the divided clock
        srst_i = 1'b1;
        tick;
        srst_i = 1'b0;
        chk("reset again", 72'h0, 72'({ovr, flag, mclk}));
        for (int k = 1; k < 5; k++)
        begin
            tick;
            chk("mod clk", 72'(k[0]), 72'(mclk));
        end
        $display("overrun test done");
    endtask : t_over
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    initial
    begin
        for (int i = 0; i < 3; i++)
            cfg[i].gain = 24'h800000;
        repeat (12) tick;
        srst_i = 1'b0;
        chk("reset", 72'({3'b000, 16'hffff, 9'h0}), 72'({ovr, flag, err, rc, programmable_gain_stage}));
        t_frame;
        t_cal;
        t_crc;
        t_over;
        end_sim;
    end
endmodule : adc_sample_acquisition_tb
`default_nettype wire
